//--- design/adc_ctl_pkg.sv
// Package for the converter control/status block: register map, field
// positions, reset values and sequencer states.
// Assumes a single 40 MHz system clock and an 8-bit register port.
package adc_ctl_pkg;

  // Register port geometry
  localparam int          ADDR_W   = 4;
  localparam int          DATA_W   = 8;
  localparam int          CH_W     = 3;

  // Register offset of the control/status register
  localparam logic [3:0]  CTRL_STATUS_OFFSET = 4'h0;

  // Field positions inside the control/status register
  localparam int          FLAG_BIT  = 7;
  localparam int          IE_BIT    = 6;
  localparam int          START_BIT = 5;
  localparam int          SCAN_BIT  = 4;

  // Reset values of the fields
  localparam logic        FLAG_RESET  = 1'b0;
  localparam logic        IE_RESET    = 1'b0;
  localparam logic        START_RESET = 1'b0;
  localparam logic        SCAN_RESET  = 1'b0;
  localparam logic [3:0]  RSVD_VALUE  = 4'h0;
  localparam logic [7:0]  READ_IDLE   = 8'h00;

  // Control/status register image, bit 7 first
  typedef struct packed {
    logic       conv_end_flag;
    logic       conv_end_irq_enable;
    logic       conv_start_bit;
    logic       scan_mode;
    logic [3:0] rsvd;
  } ctrl_status_t;

  // Request towards the analog converter core
  typedef struct packed {
    logic            go;
    logic            abort;
    logic [CH_W-1:0] channel;
  } conv_req_t;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_LAUNCH,
    SEQ_WAIT
  } seq_state_t;

endpackage

//--- design/trig_edge.sv
// Edge detector for a conversion trigger input; gives a one-cycle pulse.
// Assumes the input is already synchronous to the system clock.
`timescale 1ns/1ps
module trig_edge #(
  parameter bit FALLING = 1'b1
) (
  input  wire logic clk,       // System clock
  input  wire logic resetn,    // Asynchronous reset, active low
  input  wire logic level_in,  // Trigger level
  output logic      pulse      // One-cycle pulse on the chosen edge
);

  logic prev;
  wire  logic hit;

  // Falling or rising edge depending on the parameter
  assign hit = FALLING ? (prev & ~level_in) : (~prev & level_in);

  // Previous level and registered pulse; idle level assumed inactive
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev  <= FALLING;
      pulse <= 1'b0;
    end else begin
      prev  <= level_in;
      pulse <= hit;
    end
  end

endmodule

//--- design/adc_control_status_logic.sv
// Control and status logic of an on-chip A/D converter: one 8-bit
// control/status register, trigger handling and the channel sequencer.
// Assumes an analog core that takes a go pulse with a channel number and
// answers with a one-cycle done pulse; all inputs synchronous to CLK_SYS.
// Result registers, channel multiplexing and conversion timing sit in the
// analog side; this block only sequences requests and keeps the flags.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module adc_control_status_logic #(
  parameter int ADDR_W = adc_ctl_pkg::ADDR_W,
  parameter int CH_W   = adc_ctl_pkg::CH_W
) (
  input  wire logic                  CLK_SYS,               // System clock, 40 MHz
  input  wire logic                  RESETN,                // Async reset, active low
  input  wire logic [ADDR_W-1:0]     ADDR,                  // Register address
  input  wire logic [7:0]            WDATA,                 // Write data
  input  wire logic                  WR,                    // Write strobe
  input  wire logic                  RD,                    // Read strobe
  output logic      [7:0]            RDATA,                 // Read data, cycle after RD
  input  wire logic                  TIMER_CONV_TRIGGER,    // Timer start pulse
  input  wire logic                  EXT_CONV_TRIGGER_PIN_N,// External trigger pin
  input  wire logic                  SW_STANDBY,            // Software standby level
  input  wire logic                  HW_STANDBY,            // Hardware standby level
  input  wire logic                  MODULE_STOP,           // Module stop level
  input  wire logic [CH_W-1:0]       SEL_CHANNEL,           // Channel / last of group
  output adc_ctl_pkg::conv_req_t     CONV_REQ,              // Request to analog core
  input  wire logic                  CONV_DONE,             // Channel conversion done
  output logic                       CONV_BUSY,             // Sequencer not idle
  input  wire logic                  DTC_ACTIVE,            // Transfer ctrl serving irq
  input  wire logic                  DTC_RESULT_READ,       // Transfer ctrl reads result
  output logic                       CONV_END_INTERRUPT     // Conversion-end request
);

  // Register fields
  logic                    conv_end_flag;
  logic                    conv_end_irq_enable;
  logic                    conv_start_bit;
  logic                    scan_mode;
  logic                    flag_read_armed;

  // Sequencer state
  adc_ctl_pkg::seq_state_t state;
  adc_ctl_pkg::seq_state_t next_state;
  logic [CH_W-1:0]         channel;
  logic [CH_W-1:0]         next_channel;
  logic                    run_scan;

  // Next values
  logic                    next_flag;
  logic                    next_start;
  logic                    next_armed;
  logic [7:0]              next_rdata;

  // Decoded strobes and events
  wire  logic              sel_reg;
  wire  logic              reg_wr;
  wire  logic              reg_rd;
  wire  logic              ext_trig_pulse;
  wire  logic              trig_start;
  wire  logic              power_stop;
  wire  logic              sw_flag_clear;
  wire  logic              dtc_flag_clear;
  wire  logic              done_seen;
  wire  logic              last_channel;
  wire  logic              single_done;
  wire  logic              scan_group_done;
  wire  logic              set_flag;
  wire  logic              start_launch;
  wire  logic              abort_now;
  wire  logic              next_ie;
  wire  logic              next_go;
  wire  logic              next_busy;
  wire  logic              next_irq;
  wire  logic [CH_W-1:0]   launch_channel;
  wire  logic [CH_W-1:0]   channel_inc;
  wire  adc_ctl_pkg::ctrl_status_t reg_image;
  wire  adc_ctl_pkg::ctrl_status_t wr_image;

  // Address decode, used for both strobes
  function automatic logic hits_reg(input logic [ADDR_W-1:0] a);
    hits_reg = (a == ADDR_W'(adc_ctl_pkg::CTRL_STATUS_OFFSET));
  endfunction

  // Sequencer is parked and free to launch
  function automatic logic seq_idle(input adc_ctl_pkg::seq_state_t s);
    seq_idle = (s == adc_ctl_pkg::SEQ_IDLE);
  endfunction

  // External trigger pin fires on its falling edge
  trig_edge #(
    .FALLING  (1'b1)
  ) u_ext_edge (
    .clk      (CLK_SYS),
    .resetn   (RESETN),
    .level_in (EXT_CONV_TRIGGER_PIN_N),
    .pulse    (ext_trig_pulse)
  );

  // Register port decode
  assign sel_reg  = hits_reg(ADDR);
  assign reg_wr   = WR & sel_reg;
  assign reg_rd   = RD & sel_reg;
  assign wr_image = adc_ctl_pkg::ctrl_status_t'(WDATA);
  assign next_ie  = reg_wr ? wr_image.conv_end_irq_enable : conv_end_irq_enable;

  // Readback image; reserved bits read as zero
  assign reg_image = '{conv_end_flag:       conv_end_flag,
                       conv_end_irq_enable: conv_end_irq_enable,
                       conv_start_bit:      conv_start_bit,
                       scan_mode:           scan_mode,
                       rsvd:                adc_ctl_pkg::RSVD_VALUE};

  // Any standby or module-stop level stops the converter
  assign power_stop = SW_STANDBY | HW_STANDBY | MODULE_STOP;

  // Hardware start sources: timer pulse or pin edge
  assign trig_start = (TIMER_CONV_TRIGGER | ext_trig_pulse) & ~power_stop;

  // Flag clear sources
  assign sw_flag_clear  = reg_wr & ~wr_image.conv_end_flag & flag_read_armed;
  assign dtc_flag_clear = DTC_ACTIVE & DTC_RESULT_READ;

  // Sequencer completion events; late done after abort is ignored
  assign done_seen       = (state == adc_ctl_pkg::SEQ_WAIT) & CONV_DONE & conv_start_bit;
  assign last_channel    = (channel == SEL_CHANNEL);
  assign single_done     = done_seen & ~run_scan;
  assign scan_group_done = done_seen & run_scan & last_channel;
  assign set_flag        = single_done | scan_group_done;

  // Launch on start bit while idle, abort when start bit falls mid-run
  assign start_launch = seq_idle(state) & conv_start_bit;
  assign abort_now    = ~seq_idle(state) & ~conv_start_bit;

  // Channel of the first launch and the step to the next one in a scan
  assign launch_channel = scan_mode ? '0 : SEL_CHANNEL;
  assign channel_inc    = CH_W'(channel + 1'b1);

  // Flag next value; a completion in the clearing cycle wins
  always_comb begin
    next_flag = conv_end_flag;
    if (sw_flag_clear || dtc_flag_clear) begin
      next_flag = 1'b0;
    end
    if (set_flag) begin
      next_flag = 1'b1;
    end
  end

  // Read-before-clear tracking: armed by reading the flag as 1
  always_comb begin
    next_armed = flag_read_armed;
    if (reg_wr) begin
      next_armed = 1'b0;
    end
    if (reg_rd) begin
      next_armed = conv_end_flag;
    end
    if (!conv_end_flag) begin
      next_armed = 1'b0;
    end
  end

  // Start bit next value: power stop, then triggers over auto-clear
  always_comb begin
    next_start = conv_start_bit;
    if (single_done) begin
      next_start = 1'b0;
    end
    if (reg_wr) begin
      next_start = wr_image.conv_start_bit;
    end
    if (trig_start) begin
      next_start = 1'b1;
    end
    if (power_stop) begin
      next_start = 1'b0;
    end
  end

  // Sequencer next state and channel
  always_comb begin
    next_state   = state;
    next_channel = channel;
    unique case (state)
      adc_ctl_pkg::SEQ_IDLE: begin
        if (start_launch) begin
          next_state   = adc_ctl_pkg::SEQ_LAUNCH;
          next_channel = launch_channel;
        end
      end
      adc_ctl_pkg::SEQ_LAUNCH: begin
        next_state = adc_ctl_pkg::SEQ_WAIT;
      end
      adc_ctl_pkg::SEQ_WAIT: begin
        if (done_seen) begin
          if (!run_scan) begin
            next_state = adc_ctl_pkg::SEQ_IDLE;
          end else begin
            next_state   = adc_ctl_pkg::SEQ_LAUNCH;
            next_channel = last_channel ? '0 : channel_inc;
          end
        end
      end
    endcase
    if (abort_now) begin
      next_state = adc_ctl_pkg::SEQ_IDLE;
    end
  end

  // Read data: register image in the cycle after an RD to the register offset, zero otherwise
  assign next_rdata = reg_rd ? reg_image : adc_ctl_pkg::READ_IDLE;

  // Output next values; the interrupt sees the enable as it stands after this edge
  assign next_go   = (next_state == adc_ctl_pkg::SEQ_LAUNCH);
  assign next_busy = ~seq_idle(next_state);
  assign next_irq  = next_flag & next_ie;

  // Conversion-end flag
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      conv_end_flag <= adc_ctl_pkg::FLAG_RESET;
    end else begin
      conv_end_flag <= next_flag;
    end
  end

  // Armed by a read that saw the flag set
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      flag_read_armed <= 1'b0;
    end else begin
      flag_read_armed <= next_armed;
    end
  end

  // Start bit
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      conv_start_bit <= adc_ctl_pkg::START_RESET;
    end else begin
      conv_start_bit <= next_start;
    end
  end

  // Interrupt enable
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      conv_end_irq_enable <= adc_ctl_pkg::IE_RESET;
    end else begin
      conv_end_irq_enable <= next_ie;
    end
  end

  // Scan mode select
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      scan_mode <= adc_ctl_pkg::SCAN_RESET;
    end else if (reg_wr) begin
      scan_mode <= wr_image.scan_mode;
    end
  end

  // Sequencer state
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state <= adc_ctl_pkg::SEQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Channel being converted
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      channel <= '0;
    end else begin
      channel <= next_channel;
    end
  end

  // Mode latched at launch so a stray change mid-run is harmless
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      run_scan <= 1'b0;
    end else if (start_launch) begin
      run_scan <= scan_mode;
    end
  end

  // Read data
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= adc_ctl_pkg::READ_IDLE;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // Request to the analog core
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      CONV_REQ <= '0;
    end else begin
      CONV_REQ.go      <= next_go;
      CONV_REQ.abort   <= abort_now;
      CONV_REQ.channel <= next_channel;
    end
  end

  // Busy level
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      CONV_BUSY <= 1'b0;
    end else begin
      CONV_BUSY <= next_busy;
    end
  end

  // Conversion-end interrupt request
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      CONV_END_INTERRUPT <= 1'b0;
    end else begin
      CONV_END_INTERRUPT <= next_irq;
    end
  end

endmodule

//--- testbench/adc_ctl_properties.sv
// Port-level checks for the converter control/status block.
// Assumes it is bound to the block top; single clock domain.
`timescale 1ns/1ps
module adc_ctl_properties #(
  parameter int ADDR_W = 4,
  parameter int CH_W   = 3
) (
  input wire logic                   CLK_SYS,                 // Clock
  input wire logic                   RESETN,                  // Reset
  input wire logic [ADDR_W-1:0]      ADDR,                    // Address
  input wire logic [7:0]             WDATA,                   // Write data
  input wire logic                   WR,                      // Write strobe
  input wire logic                   RD,                      // Read strobe
  input wire logic [7:0]             RDATA,                   // Read data
  input wire logic                   TIMER_CONV_TRIGGER,      // Timer start
  input wire logic                   EXT_CONV_TRIGGER_PIN_N,  // Pin start
  input wire logic                   SW_STANDBY,              // Standby
  input wire logic                   HW_STANDBY,              // Standby
  input wire logic                   MODULE_STOP,             // Module stop
  input wire logic [CH_W-1:0]        SEL_CHANNEL,             // Channel select
  input wire adc_ctl_pkg::conv_req_t CONV_REQ,                // Core request
  input wire logic                   CONV_BUSY,               // Sequencer busy
  input wire logic                   CONV_DONE,               // Core done
  input wire logic                   DTC_ACTIVE,              // Transfer active
  input wire logic                   DTC_RESULT_READ,         // Result read
  input wire logic                   CONV_END_INTERRUPT       // Interrupt
);
  // Any power-down request
  wire logic stop = SW_STANDBY | HW_STANDBY | MODULE_STOP;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  // Read data stands only after a mapped read
  property p_rd_idle; !$past(RD) || $past(ADDR) != 4'h0 |-> RDATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_irq_img; $past(RD && ADDR == 4'h0 && CONV_END_INTERRUPT) |-> RDATA[7:6] == 2'b11;
  endproperty
  a_irq_img: assert property (p_irq_img) else $error("irq without flag and enable");
  property p_ie_off; WR && ADDR == 4'h0 && !WDATA[6] |=> !CONV_END_INTERRUPT; endproperty
  a_ie_off: assert property (p_ie_off) else $error("irq while disabled");
  property p_go; CONV_REQ.go |-> CONV_BUSY ##1 !CONV_REQ.go; endproperty
  a_go: assert property (p_go) else $error("launch pulse wrong");
  property p_abort; CONV_REQ.abort |-> !CONV_BUSY && !CONV_REQ.go; endproperty
  a_abort: assert property (p_abort) else $error("abort left busy");
  property p_ch; CONV_REQ.go |-> CONV_REQ.channel <= SEL_CHANNEL; endproperty
  a_ch: assert property (p_ch) else $error("channel out of group");
  property p_timer; TIMER_CONV_TRIGGER && !CONV_BUSY && !stop |-> ##[1:2] CONV_REQ.go;
  endproperty
  a_timer: assert property (p_timer) else $error("timer did not start");
  property p_pin; $fell(EXT_CONV_TRIGGER_PIN_N) && !CONV_BUSY && !stop |-> ##[2:4] CONV_REQ.go;
  endproperty
  a_pin: assert property (p_pin) else $error("pin did not start");
  property p_dtc; DTC_ACTIVE && DTC_RESULT_READ && !CONV_DONE |=> !CONV_END_INTERRUPT; endproperty
  a_dtc: assert property (p_dtc) else $error("transfer read kept flag");
  property p_stop; stop [*3] |-> !CONV_BUSY; endproperty
  a_stop: assert property (p_stop) else $error("busy during power stop");
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the converter control/status block.
// Bench drives every input port itself; the checker is bound at the foot.
`timescale 1ns/1ps
module testbench;
  logic CLK_SYS, RESETN, WR, RD, TIMER_CONV_TRIGGER, EXT_CONV_TRIGGER_PIN_N;
  logic SW_STANDBY, HW_STANDBY, MODULE_STOP, CONV_DONE, DTC_ACTIVE, DTC_RESULT_READ;
  logic CONV_BUSY, CONV_END_INTERRUPT;
  logic [3:0] ADDR;
  logic [7:0] WDATA, RDATA;
  logic [2:0] SEL_CHANNEL;
  adc_ctl_pkg::conv_req_t CONV_REQ;
  int errors, samples_checked, cycles;

  adc_control_status_logic DUT (
    .CLK_SYS(CLK_SYS),
    .RESETN(RESETN),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .WR(WR),
    .RD(RD),
    .RDATA(RDATA),
    .TIMER_CONV_TRIGGER(TIMER_CONV_TRIGGER),
    .EXT_CONV_TRIGGER_PIN_N(EXT_CONV_TRIGGER_PIN_N),
    .SW_STANDBY(SW_STANDBY),
    .HW_STANDBY(HW_STANDBY),
    .MODULE_STOP(MODULE_STOP),
    .SEL_CHANNEL(SEL_CHANNEL),
    .CONV_REQ(CONV_REQ),
    .CONV_DONE(CONV_DONE),
    .CONV_BUSY(CONV_BUSY),
    .DTC_ACTIVE(DTC_ACTIVE),
    .DTC_RESULT_READ(DTC_RESULT_READ),
    .CONV_END_INTERRUPT(CONV_END_INTERRUPT)
  );

  // 40 MHz clock and hang limit
  always #12.5 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register port cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1 check(RDATA, exp);
  endtask

  // Wait for a launch and check its channel
  task automatic wait_go(input logic [2:0] ch);
    int n;
    n = 0;
    // A launch already standing when called is taken at once
    while (CONV_REQ.go !== 1'b1 && n < 40) begin
      @(posedge CLK_SYS);
      #1 n++;
    end
    check({CONV_REQ.go, 4'h0, CONV_REQ.channel}, {1'b1, 4'h0, ch});
  endtask
  // Launch, then answer with one done pulse
  task automatic conv(input logic [2:0] ch);
    wait_go(ch);
    @(posedge CLK_SYS);
    CONV_DONE <= 1'b1;
    @(posedge CLK_SYS);
    CONV_DONE <= 1'b0;
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {CLK_SYS, RESETN, WR, RD, TIMER_CONV_TRIGGER, CONV_DONE} = 6'h00;
    {SW_STANDBY, HW_STANDBY, MODULE_STOP, DTC_ACTIVE, DTC_RESULT_READ} = 5'h00;
    EXT_CONV_TRIGGER_PIN_N = 1'b1;
    ADDR = 4'h0;
    WDATA = 8'h00;
    SEL_CHANNEL = 3'h5;
    {errors, samples_checked, cycles} = '0;
    repeat (16) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h50);
    rd(4'h0, 8'h50);
    wr(4'h0, 8'hD0);
    rd(4'h0, 8'h50);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h0, 8'h50);
    // Single mode by software start
    wr(4'h0, 8'h60);
    conv(3'h5);
    check({6'h0, CONV_BUSY, CONV_END_INTERRUPT}, 8'h01);
    wr(4'h0, 8'h40);
    check({7'h0, CONV_END_INTERRUPT}, 8'h01);
    rd(4'h0, 8'hC0);
    wr(4'h0, 8'h40);
    rd(4'h0, 8'h40);
    // Timer start, then transfer read clears
    @(posedge CLK_SYS);
    TIMER_CONV_TRIGGER <= 1'b1;
    @(posedge CLK_SYS);
    TIMER_CONV_TRIGGER <= 1'b0;
    conv(3'h5);
    check({7'h0, CONV_END_INTERRUPT}, 8'h01);
    wr(4'h0, 8'h00);
    check({7'h0, CONV_END_INTERRUPT}, 8'h00);
    wr(4'h0, 8'h40);
    check({7'h0, CONV_END_INTERRUPT}, 8'h01);
    @(posedge CLK_SYS);
    {DTC_ACTIVE, DTC_RESULT_READ} <= 2'b11;
    @(posedge CLK_SYS);
    {DTC_ACTIVE, DTC_RESULT_READ} <= 2'b00;
    #1 check({7'h0, CONV_END_INTERRUPT}, 8'h00);
    // Pin start with interrupt disabled
    wr(4'h0, 8'h00);
    @(posedge CLK_SYS);
    EXT_CONV_TRIGGER_PIN_N <= 1'b0;
    conv(3'h5);
    @(posedge CLK_SYS);
    EXT_CONV_TRIGGER_PIN_N <= 1'b1;
    #1 check({7'h0, CONV_END_INTERRUPT}, 8'h00);
    rd(4'h0, 8'h80);
    // Scan over channels 0..2, flag only after the last
    @(posedge CLK_SYS);
    SEL_CHANNEL <= 3'h2;
    wr(4'h0, 8'h70);
    for (int k = 0; k < 2; k++) begin
      conv(k[2:0]);
      check({7'h0, CONV_END_INTERRUPT}, 8'h00);
    end
    conv(3'h2);
    check({7'h0, CONV_END_INTERRUPT}, 8'h01);
    wait_go(3'h0);
    rd(4'h0, 8'hF0);
    wr(4'h0, 8'h10);
    @(posedge CLK_SYS);
    #1 check({6'h0, CONV_REQ.abort, CONV_BUSY}, 8'h02);
    // Each power-down source stops a scan
    for (int i = 0; i < 3; i++) begin
      wr(4'h0, 8'h30);
      wait_go(3'h0);
      @(posedge CLK_SYS);
      {MODULE_STOP, HW_STANDBY, SW_STANDBY} <= 3'b001 << i;
      repeat (3) @(posedge CLK_SYS);
      #1 check({7'h0, CONV_BUSY}, 8'h00);
      rd(4'h0, 8'h10);
      @(posedge CLK_SYS);
      {MODULE_STOP, HW_STANDBY, SW_STANDBY} <= 3'b000;
    end
    print_verdict();
  end
endmodule

bind adc_control_status_logic adc_ctl_properties #(.ADDR_W(ADDR_W), .CH_W(CH_W)) u_props (
  .CLK_SYS(CLK_SYS),
  .RESETN(RESETN),
  .ADDR(ADDR),
  .WDATA(WDATA),
  .WR(WR),
  .RD(RD),
  .RDATA(RDATA),
  .TIMER_CONV_TRIGGER(TIMER_CONV_TRIGGER),
  .EXT_CONV_TRIGGER_PIN_N(EXT_CONV_TRIGGER_PIN_N),
  .SW_STANDBY(SW_STANDBY),
  .HW_STANDBY(HW_STANDBY),
  .MODULE_STOP(MODULE_STOP),
  .SEL_CHANNEL(SEL_CHANNEL),
  .CONV_REQ(CONV_REQ),
  .CONV_BUSY(CONV_BUSY),
  .CONV_DONE(CONV_DONE),
  .DTC_ACTIVE(DTC_ACTIVE),
  .DTC_RESULT_READ(DTC_RESULT_READ),
  .CONV_END_INTERRUPT(CONV_END_INTERRUPT)
);
